// file: design/flash_pwr_pkg.sv
// constants and carrier types for the flash reset and deep power-down controller
// Function
// - reset low: no operation, inputs ignored, all outputs high impedance
// - leaving reset: asynchronous read-array mode, status register becomes 0080h
// - reset during program or erase aborts it, location becomes invalid
// - reset completes within pulse minimum idle, within 25 us when busy
// - after array read with quiet address, enter standby automatically
// - deep sleep needs config bit 15, reset and select high, pin asserted
// - deep sleep entry aborts program or erase; suspended work is lost
// - in deep sleep only sleep pin and reset are heeded
// - deep sleep keeps modes, config, locks; status 0080h, errors cleared
// - leave deep sleep on pin release; host waits 75 us before select
// - config bit 14 zero makes sleep pin active low
package flash_pwr_pkg;

  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned RESET_PULSE_MIN_NS = 100;
  localparam int unsigned RESET_PULSE_MIN_CYC =
    (RESET_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RESET_ABORT_LATENCY_US = 25;
  localparam int unsigned RESET_ABORT_LATENCY_CYC =
    RESET_ABORT_LATENCY_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned SLEEP_EXIT_TO_SELECT_US = 75;
  localparam int unsigned SLEEP_EXIT_TO_SELECT_CYC =
    SLEEP_EXIT_TO_SELECT_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned IDLE_CYC_TO_SAVE = 4;

  localparam int unsigned CFG_SLEEP_EN_BIT = 15;
  localparam int unsigned CFG_SLEEP_POL_BIT = 14;
  localparam int unsigned STATUS_ERR_LO = 1;
  localparam int unsigned STATUS_ERR_HI = 5;
  localparam logic [15:0] STATUS_RESET_VALUE = 16'h0080;
  localparam logic [15:0] CFG_RESET_VALUE = 16'h0000;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned CNT_W = 16;

  typedef enum logic [1:0] {
    MODE_READ_ARRAY,
    MODE_READ_STATUS,
    MODE_READ_ID
  } read_mode_type;

  typedef struct packed {
    logic              select_b;
    logic              out_en_b;
    logic              write_en_b;
    logic [ADDR_W-1:0] addr;
  } bus_in_type;

  typedef struct packed {
    logic              start_prog;
    logic              start_erase;
    logic              suspend;
    logic              resume;
    logic              work_done;
    logic              work_error;
    logic [15:0]       cfg_wdata;
    logic              cfg_write;
    read_mode_type     mode_wdata;
    logic              mode_write;
  } core_cmd_type;

endpackage

// file: design/idle_timer.sv
// saturating down counter used for power-saving and deep sleep exit timing
`timescale 1ns/10ps
module idle_timer
  import flash_pwr_pkg::*;
(
  input  wire logic             mclk_i,
  input  wire logic             rst_b_i,
  input  wire logic             load_i,
  input  wire logic [CNT_W-1:0] value_i,
  output logic                  expired_o
);

  logic [CNT_W-1:0] count;

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      count <= '0;
    end else if (load_i) begin
      count <= value_i;
    end else if (count != '0) begin
      count <= count - 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      expired_o <= 1'b0;
    end else begin
      expired_o <= !load_i && (count <= CNT_W'(1));
    end
  end

endmodule

// file: design/flash_reset_deep_powerdown.sv
// reset, automatic power saving and deep power-down control of the flash core
`timescale 1ns/10ps
module flash_reset_deep_powerdown
  import flash_pwr_pkg::*;
(
  input  wire logic          mclk_i,
  input  wire logic          rst_b_i,
  input  wire logic          flash_reset_b_i,
  input  wire logic          deep_sleep_pin_i,
  input  wire bus_in_type    bus_i,
  input  wire core_cmd_type  cmd_i,
  output logic               out_drive_o,
  output logic               wait_drive_o,
  output logic               busy_o,
  output logic               suspended_o,
  output logic               abort_o,
  output logic               location_invalid_o,
  output logic               standby_o,
  output logic               deep_sleep_o,
  output logic               ready_o,
  output logic [15:0]        status_o,
  output logic [15:0]        extended_config_word_o,
  output read_mode_type      read_mode_o
);

  typedef enum logic [2:0] {
    ST_RESET,
    ST_ACTIVE,
    ST_SAVE,
    ST_DEEP,
    ST_EXIT
  } pwr_state_type;

  pwr_state_type     state;
  pwr_state_type     next_state;
  logic              sleep_asserted;
  logic              sleep_entry;
  logic              bus_live;
  logic              read_cycle;
  logic [ADDR_W-1:0] last_addr;
  logic              addr_quiet;
  logic              idle_expired;
  logic              exit_expired;
  logic              in_reset;

  // held reset pin acts as device reset; host keeps its pulse width
  assign in_reset = !flash_reset_b_i;

  assign sleep_asserted = extended_config_word_o[CFG_SLEEP_POL_BIT]
                          ? deep_sleep_pin_i : !deep_sleep_pin_i;

  assign sleep_entry = extended_config_word_o[CFG_SLEEP_EN_BIT] && !in_reset
                       && bus_i.select_b && sleep_asserted;

  assign bus_live = (state == ST_ACTIVE || state == ST_SAVE) && !in_reset;
  assign read_cycle = bus_live && !bus_i.select_b && !bus_i.out_en_b;
  assign addr_quiet = bus_i.addr == last_addr;

  always_comb begin
    next_state = state;
    unique case (state)
      ST_RESET: begin
        if (!in_reset) begin
          next_state = ST_ACTIVE;
        end
      end
      ST_ACTIVE: begin
        if (sleep_entry) begin
          next_state = ST_DEEP;
        end else if (idle_expired && addr_quiet && bus_i.out_en_b) begin
          next_state = ST_SAVE;
        end
      end
      ST_SAVE: begin
        if (sleep_entry) begin
          next_state = ST_DEEP;
        end else if (!addr_quiet || read_cycle) begin
          // selected but quiet stays saving; only a new read or address wakes
          next_state = ST_ACTIVE;
        end
      end
      ST_DEEP: begin
        if (!sleep_asserted || in_reset) begin
          next_state = ST_EXIT;
        end
      end
      ST_EXIT: begin
        if (sleep_entry) begin
          next_state = ST_DEEP;
        end else if (exit_expired && !in_reset) begin
          // a stale expiry must not wake the core while reset is held
          next_state = ST_ACTIVE;
        end
      end
      default: next_state = ST_RESET;
    endcase
    if (in_reset && state != ST_DEEP && state != ST_EXIT) begin
      next_state = ST_RESET;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state <= ST_RESET;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      last_addr <= '0;
    end else if (bus_live) begin
      last_addr <= bus_i.addr;
    end
  end

  // idle time before power saving; reloaded by every read or address change
  idle_timer u_idle (
    .mclk_i    (mclk_i),
    .rst_b_i   (rst_b_i),
    .load_i    (read_cycle || !addr_quiet || state != ST_ACTIVE),
    .value_i   (CNT_W'(IDLE_CYC_TO_SAVE)),
    .expired_o (idle_expired)
  );

  // exit delay after deep sleep, also after reset released in deep sleep
  idle_timer u_exit (
    .mclk_i    (mclk_i),
    .rst_b_i   (rst_b_i),
    .load_i    (state != ST_EXIT || in_reset),
    .value_i   (CNT_W'(SLEEP_EXIT_TO_SELECT_CYC)),
    .expired_o (exit_expired)
  );

  // program/erase tracking; abort is immediate, well inside the 25 us bound
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      busy_o      <= 1'b0;
      suspended_o <= 1'b0;
    end else if (in_reset || next_state == ST_DEEP) begin
      busy_o      <= 1'b0;
      suspended_o <= 1'b0;
    end else if (bus_live && !busy_o && !suspended_o
                 && (cmd_i.start_prog || cmd_i.start_erase)) begin
      busy_o <= 1'b1;
    end else if (busy_o && cmd_i.suspend) begin
      busy_o      <= 1'b0;
      suspended_o <= 1'b1;
    end else if (suspended_o && cmd_i.resume && bus_live) begin
      busy_o      <= 1'b1;
      suspended_o <= 1'b0;
    end else if (busy_o && cmd_i.work_done) begin
      busy_o <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      abort_o            <= 1'b0;
      location_invalid_o <= 1'b0;
    end else begin
      abort_o <= (busy_o || suspended_o) && (in_reset || next_state == ST_DEEP);
      if ((busy_o || suspended_o) && (in_reset || next_state == ST_DEEP)) begin
        location_invalid_o <= 1'b1;
      end else if (busy_o && cmd_i.work_done) begin
        location_invalid_o <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      status_o <= STATUS_RESET_VALUE;
    end else if (in_reset || state == ST_DEEP) begin
      status_o <= STATUS_RESET_VALUE;
    end else begin
      status_o[7] <= !busy_o;
      if (busy_o && cmd_i.work_error) begin
        status_o[STATUS_ERR_HI:STATUS_ERR_LO] <= '1;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      extended_config_word_o <= CFG_RESET_VALUE;
    end else if (bus_live && cmd_i.cfg_write) begin
      extended_config_word_o <= cmd_i.cfg_wdata;
    end
  end

  // modes keep through deep sleep; reset returns to array read
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      read_mode_o <= MODE_READ_ARRAY;
    end else if (in_reset) begin
      read_mode_o <= MODE_READ_ARRAY;
    end else if (bus_live && cmd_i.mode_write) begin
      read_mode_o <= cmd_i.mode_wdata;
    end
  end

  // outputs released while reset or asleep
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      out_drive_o  <= 1'b0;
      wait_drive_o <= 1'b0;
    end else begin
      out_drive_o  <= read_cycle;
      wait_drive_o <= bus_live && !bus_i.select_b;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      standby_o    <= 1'b0;
      deep_sleep_o <= 1'b0;
      ready_o      <= 1'b0;
    end else begin
      standby_o    <= next_state == ST_SAVE;
      deep_sleep_o <= next_state == ST_DEEP;
      ready_o      <= next_state == ST_ACTIVE || next_state == ST_SAVE;
    end
  end

endmodule

// file: test/flash_pwr_sva.sv
// assertions on the flash reset and deep power-down controller
`timescale 1ns/10ps
module flash_pwr_sva
  import flash_pwr_pkg::*;
(
  input wire logic        mclk_i,
  input wire logic        rst_b_i,
  input wire logic        flash_reset_b_i,
  input wire logic        deep_sleep_pin_i,
  input wire bus_in_type  bus_i,
  input wire logic        out_drive_o,
  input wire logic        busy_o,
  input wire logic        abort_o,
  input wire logic        location_invalid_o,
  input wire logic        deep_sleep_o,
  input wire logic        ready_o,
  input wire logic [15:0] status_o,
  input wire logic [15:0] extended_config_word_o
);
  logic on;
  logic go;
  assign on = deep_sleep_pin_i == extended_config_word_o[CFG_SLEEP_POL_BIT];
  // entry judged on the registered word, not the write strobe
  assign go = extended_config_word_o[CFG_SLEEP_EN_BIT] && bus_i.select_b
    && flash_reset_b_i && on;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  property p_q; !flash_reset_b_i |=> !out_drive_o && !ready_o; endproperty
  a_q: assert property (p_q) else $error("output on in reset");
  property p_s; !flash_reset_b_i |=> status_o == 16'h0080; endproperty
  a_s: assert property (p_s) else $error("status not cleared");
  property p_a;
    !flash_reset_b_i && busy_o |=> abort_o && location_invalid_o && !busy_o;
  endproperty
  a_a: assert property (p_a) else $error("work not aborted");
  property p_d; !flash_reset_b_i [*2] |=> !busy_o && !abort_o; endproperty
  a_d: assert property (p_d) else $error("reset not done");
  property p_e; $rose(deep_sleep_o) |-> $past(go); endproperty
  a_e: assert property (p_e) else $error("sleep without cause");
  property p_k; $rose(deep_sleep_o) && $past(busy_o) |-> ##[0:1] abort_o; endproperty
  a_k: assert property (p_k) else $error("sleep kept work");
  property p_i; deep_sleep_o |-> !ready_o && !out_drive_o && !busy_o; endproperty
  a_i: assert property (p_i) else $error("active in sleep");
  property p_x; deep_sleep_o && !on |=> !deep_sleep_o; endproperty
  a_x: assert property (p_x) else $error("sleep not left");
  c_abort: cover property (!flash_reset_b_i && busy_o);
  c_enter: cover property ($rose(deep_sleep_o));
  c_leave: cover property ($fell(deep_sleep_o));
endmodule
bind flash_reset_deep_powerdown flash_pwr_sva u_sva (.mclk_i, .rst_b_i, .flash_reset_b_i,
  .deep_sleep_pin_i, .bus_i, .out_drive_o, .busy_o, .abort_o, .location_invalid_o,
  .deep_sleep_o, .ready_o, .status_o, .extended_config_word_o);

// file: test/flash_host_model.sv
// host model for the flash reset, deep sleep and select pins
`timescale 1ns/10ps
module flash_host_model
  import flash_pwr_pkg::*;
(
  input  wire logic mclk_i,
  input  wire logic rst_b_i,
  output logic      flash_reset_b_o,
  output logic      deep_sleep_pin_o,
  output logic      select_b_o
);
  int n = 0;
  int free = 0;
  int on_at = 0;
  always @(posedge mclk_i) n <= n + 1;
  initial begin
    flash_reset_b_o = 1'b0;
    deep_sleep_pin_o = 1'b1;
    select_b_o = 1'b1;
    @(posedge rst_b_i);
    // unit left open, taken as clock cycles
    repeat (30) @(negedge mclk_i);
    flash_reset_b_o = 1'b1;
  end
  task automatic pulse_reset(input int c);
    flash_reset_b_o = 1'b0;
    repeat (c > RESET_PULSE_MIN_CYC ? c : RESET_PULSE_MIN_CYC) @(negedge mclk_i);
    flash_reset_b_o = 1'b1;
    free = n + SLEEP_EXIT_TO_SELECT_CYC + 1;
  endtask
  task automatic sleep(input logic pol, input logic en);
    if (en) begin
      select_b_o = 1'b1;
      on_at = n;
    end
    while (!en && n < on_at + RESET_PULSE_MIN_CYC) @(negedge mclk_i);
    deep_sleep_pin_o = en ? pol : !pol;
    if (!en) free = n + SLEEP_EXIT_TO_SELECT_CYC + 1;
  endtask
  task automatic set_select(input logic v);
    while (!v && n < free) @(negedge mclk_i);
    select_b_o = v;
  endtask
endmodule

// file: test/tb.sv
// testbench for the flash reset and deep power-down controller
`timescale 1ns/10ps
module tb
  import flash_pwr_pkg::*;
;
  logic          mclk_i = 1'b0;
  logic          rst_b_i = 1'b0;
  logic          oe_b = 1'b1;
  logic [15:0]   addr = 16'h0000;
  core_cmd_type  cmd = '0;
  logic          fr_b, pin, sel_b, od, wt, busy, susp, abrt, inv, stby, deep, rdy;
  logic [15:0]   stat, cfg;
  read_mode_type mode;
  int            miscompares = 0;
  int            total_checks = 0;
  int            n;
  always #5 mclk_i = ~mclk_i;
  flash_host_model u_host (.mclk_i, .rst_b_i, .flash_reset_b_o(fr_b),
    .deep_sleep_pin_o(pin), .select_b_o(sel_b));
  flash_reset_deep_powerdown u_dut (.mclk_i, .rst_b_i, .flash_reset_b_i(fr_b),
    .deep_sleep_pin_i(pin), .bus_i({sel_b, oe_b, 1'b1, addr}), .cmd_i(cmd),
    .out_drive_o(od), .wait_drive_o(wt), .busy_o(busy), .suspended_o(susp), .abort_o(abrt),
    .location_invalid_o(inv), .standby_o(stby), .deep_sleep_o(deep), .ready_o(rdy),
    .status_o(stat), .extended_config_word_o(cfg), .read_mode_o(mode));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int c);
    repeat (c) @(negedge mclk_i);
  endtask
  task automatic wait_ready(input int lim);
    n = 0;
    while (rdy !== 1'b1 && n < lim) begin
      cyc(1);
      n++;
    end
    check(16'(rdy), 16'h0001);
  endtask
  task automatic put_cfg(input logic [15:0] v);
    cmd.cfg_wdata = v;
    cmd.cfg_write = 1'b1;
    cyc(1);
    cmd = '0;
  endtask
  task automatic t_reset;
    cyc(4);
    check(16'({od, wt, rdy}), 16'h0000);
    check(stat, 16'h0080);
    wait_ready(40);
    check(16'(mode), 16'(MODE_READ_ARRAY));
  endtask
  task automatic t_abort;
    cmd.start_prog = 1'b1;
    cmd.mode_wdata = MODE_READ_STATUS;
    cmd.mode_write = 1'b1;
    cyc(1);
    cmd = '0;
    check(16'(busy), 16'h0001);
    check(16'(mode), 16'(MODE_READ_STATUS));
    fork
      u_host.pulse_reset(10);
      begin
        cyc(1);
        check(16'({abrt, inv, busy, od, wt}), 16'h0018);
        cyc(1);
        check(16'({abrt, busy}), 16'h0000);
      end
    join
    wait_ready(20);
    check(16'(mode), 16'(MODE_READ_ARRAY));
  endtask
  task automatic t_standby;
    u_host.set_select(1'b0);
    addr = 16'h1234;
    oe_b = 1'b0;
    cyc(2);
    check(16'({od, wt}), 16'h0003);
    oe_b = 1'b1;
    cyc(IDLE_CYC_TO_SAVE + 2);
    check(16'(stby), 16'h0001);
    u_host.set_select(1'b1);
  endtask
  task automatic t_sleep;
    // pin parked inactive for the coming polarity, so the erase can start
    u_host.sleep(1'b1, 1'b0);
    put_cfg(16'hC000);
    cmd.start_erase = 1'b1;
    cmd.mode_wdata = MODE_READ_ID;
    cmd.mode_write = 1'b1;
    cyc(1);
    cmd = '0;
    cmd.work_error = 1'b1;
    cyc(1);
    cmd.work_error = 1'b0;
    cmd.suspend = 1'b1;
    check(stat, 16'h003E);
    cyc(1);
    cmd = '0;
    check(16'({busy, susp}), 16'h0001);
    u_host.sleep(1'b1, 1'b1);
    cyc(1);
    check(16'({deep, abrt, inv, susp, busy, rdy}), 16'h0038);
    cyc(1);
    check(stat, 16'h0080);
    put_cfg(16'h0000);
    check(cfg, 16'hC000);
    u_host.sleep(1'b1, 1'b0);
    cyc(1);
    check(16'(deep), 16'h0000);
    wait_ready(8000);
    check(16'(n >= 7490 && n <= 7510), 16'h0001);
    check(16'(mode), 16'(MODE_READ_ID));
    cmd.resume = 1'b1;
    cyc(1);
    cmd = '0;
    check(16'({busy, susp}), 16'h0000);
  endtask
  task automatic t_low;
    put_cfg(16'h4000);
    u_host.sleep(1'b1, 1'b1);
    cyc(3);
    check(16'(deep), 16'h0000);
    u_host.sleep(1'b1, 1'b0);
    put_cfg(16'h8000);
    u_host.sleep(1'b0, 1'b1);
    cyc(2);
    check(16'(deep), 16'h0001);
    u_host.pulse_reset(10);
    u_host.sleep(1'b0, 1'b0);
    wait_ready(8000);
    check(16'(n >= 7490 && n <= 7510), 16'h0001);
    check(stat, 16'h0080);
  endtask
  task automatic give_verdict;
    $display("checks=%0d mismatches=%0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    cyc(8);
    rst_b_i = 1'b1;
    t_reset;
    t_abort;
    t_standby;
    t_sleep;
    t_low;
    give_verdict;
  end
  initial begin
    repeat (40000) @(posedge mclk_i);
    miscompares++;
    give_verdict;
  end
endmodule
